// ==== hdl/aic_pkg.sv ====
// Purpose: constants and types shared by the audio input configuration block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes:   register indices are kept as printed; byte address is four times the index
package aic_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam logic [7:0] AIC_IDX_CONFIG = 8'h02;    // audio input configuration
    localparam logic [7:0] AIC_IDX_SLOT   = 8'h03;    // slot select
    localparam logic [7:0] AIC_IDX_STATUS = 8'h3f;    // block status, read only
    localparam int         AIC_ADDR_W     = 10;       // byte address width
    localparam int         AIC_DATA_W     = 32;

    // ************************************************************
    // field layout and reset values
    // ************************************************************
    localparam logic [2:0] AIC_FMT_RJ24 = 3'h0;
    localparam logic [2:0] AIC_FMT_RJ20 = 3'h1;
    localparam logic [2:0] AIC_FMT_RJ18 = 3'h2;
    localparam logic [2:0] AIC_FMT_RJ16 = 3'h3;
    localparam logic [2:0] AIC_FMT_I2S  = 3'h4;
    localparam logic [2:0] AIC_FMT_LJ   = 3'h5;
    localparam logic [2:0] AIC_SLOT_RST = 3'h0;

    // word lengths reported by the format decode
    localparam logic [4:0] AIC_LEN_24 = 5'h18;
    localparam logic [4:0] AIC_LEN_20 = 5'h14;
    localparam logic [4:0] AIC_LEN_18 = 5'h12;
    localparam logic [4:0] AIC_LEN_16 = 5'h10;
    localparam logic [4:0] AIC_LEN_0  = 5'h00;

    // configuration register, bit 7 down to bit 0
    typedef struct packed {
        logic       dc_filter_skip;      // bit 7
        logic       slot_source_choice;  // bit 6
        logic [1:0] rsv;                 // bits 5:4
        logic       rate_speed_choice;   // bit 3
        logic [2:0] serial_word_format;  // bits 2:0
    } aic_cfg_t;

    localparam aic_cfg_t AIC_CFG_RST = '{
        dc_filter_skip:     1'b0,
        slot_source_choice: 1'b0,
        rsv:                2'h0,
        rate_speed_choice:  1'b0,
        serial_word_format: AIC_FMT_I2S
    };

    // decoded view of the configuration for the serial receiver
    typedef struct packed {
        logic [2:0] active_slot;       // playback channel in use
        logic [4:0] word_len;          // data bits per word
        logic       format_reserved;   // reserved format code programmed
    } aic_decode_t;

    // dc blocker: estimator time constant as a right shift
    localparam int AIC_DC_SHIFT = 10;
endpackage

// ==== hdl/aic_config.sv ====
// Purpose: audio input configuration register with slot select and dc blocker
// Assumes: one clock pclk at 100 MHz, samples arrive from logic on that clock
// Notes:   APB slave, zero wait states per transfer, unmapped access gives pslverr
//
// What this block does
// - bit 7 set bypasses high-pass filter
// - enabled filter removes dc from samples
// - bit 6 picks slot from address or register
// - bit 3 speed choice is stored and read back only
// - codes 0-3 select right-justified 24/20/18/16
// - code 4 i2s is reset, 5 left-justified
// - register slot field picks playback channel when bit 6 set
module aic_config
    import aic_pkg::*;
#(
    parameter int SAMPLE_W = 24,            // audio sample width
    parameter int DC_SHIFT = AIC_DC_SHIFT   // dc estimator time constant
)(
    input  wire logic                  pclk,            // bus and block clock
    input  wire logic                  presetn,         // async reset, active low
    input  wire logic                  psel,            // apb select
    input  wire logic                  penable,         // apb access phase
    input  wire logic                  pwrite,          // apb direction
    input  wire logic [AIC_ADDR_W-1:0] paddr,           // apb byte address
    input  wire logic [AIC_DATA_W-1:0] pwdata,          // apb write data
    input  wire logic [3:0]            pstrb,           // apb byte strobes
    output logic [AIC_DATA_W-1:0]      prdata,          // apb read data
    output logic                       pready,          // apb ready
    output logic                       pslverr,         // apb error
    input  wire logic [2:0]            bus_addr_slot,   // address strap pins
    input  wire logic [SAMPLE_W-1:0]   sample_in,       // incoming audio sample
    input  wire logic                  sample_in_valid, // sample strobe
    output logic [SAMPLE_W-1:0]        sample_out,      // filtered or raw sample
    output logic                       sample_out_valid,// output strobe
    output aic_cfg_t                   cfg,             // configuration fields
    output aic_decode_t                decode           // decoded configuration
);

    // ************************************************************
    // helpers
    // ************************************************************

    // word length for a format code, zero for reserved codes
    function automatic logic [4:0] fmt_len(input logic [2:0] fmt);
        logic [4:0] len;
        len = AIC_LEN_0;
        case (fmt)
            AIC_FMT_RJ24: len = AIC_LEN_24;
            AIC_FMT_RJ20: len = AIC_LEN_20;
            AIC_FMT_RJ18: len = AIC_LEN_18;
            AIC_FMT_RJ16: len = AIC_LEN_16;
            AIC_FMT_I2S:  len = AIC_LEN_24;
            AIC_FMT_LJ:   len = AIC_LEN_24;
            default:      len = AIC_LEN_0;
        endcase
        return len;
    endfunction

    // true for a word-aligned address at the given register index
    function automatic logic hit(input logic [AIC_ADDR_W-1:0] a, input logic [7:0] idx);
        return a == {idx, 2'b00};
    endfunction

    // ************************************************************
    // register state
    // ************************************************************
    aic_cfg_t          cfg_reg;
    logic [2:0]        slot_reg;
    logic              pready_reg;
    logic              pslverr_reg;
    logic [31:0]       prdata_reg;
    aic_decode_t       decode_reg;
    logic [2:0]        strap_s1_reg;
    logic [2:0]        strap_s2_reg;
    logic [2:0]        strap_s3_reg;
    logic [2:0]        strap_reg;
    logic              setup;
    logic              wr_done;
    logic              mapped;
    logic [7:0]        status_byte;

    assign setup   = psel && !penable;
    assign wr_done = psel && penable && pready_reg && pwrite && !pslverr_reg;
    assign mapped  = hit(paddr, AIC_IDX_CONFIG) || hit(paddr, AIC_IDX_SLOT)
                   || (hit(paddr, AIC_IDX_STATUS) && !pwrite);
    assign status_byte = {decode_reg.format_reserved, 1'b0, strap_reg, decode_reg.active_slot};

    // ************************************************************
    // apb slave
    // ************************************************************

    // answer one cycle after setup, so the access phase sees pready high
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg  <= setup;
            pslverr_reg <= setup && !mapped;
        end
    end

    // read data captured in setup, held through the access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h0;
        else if (setup)
        begin
            prdata_reg <= 32'h0;
            if (!pwrite && hit(paddr, AIC_IDX_CONFIG))
                prdata_reg <= {24'h0, cfg_reg};
            else if (!pwrite && hit(paddr, AIC_IDX_SLOT))
                prdata_reg <= {29'h0, slot_reg};
            else if (!pwrite && hit(paddr, AIC_IDX_STATUS))
                prdata_reg <= {24'h0, status_byte};
        end
    end

    // configuration register; reserved bits stored as written
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cfg_reg <= AIC_CFG_RST;
        else if (wr_done && pstrb[0] && hit(paddr, AIC_IDX_CONFIG))
            cfg_reg <= aic_cfg_t'(pwdata[7:0]);
    end

    // slot select field
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            slot_reg <= AIC_SLOT_RST;
        else if (wr_done && pstrb[0] && hit(paddr, AIC_IDX_SLOT))
            slot_reg <= pwdata[2:0];
    end

    // ************************************************************
    // address strap synchroniser
    // ************************************************************

    // three stages; a new value is taken once stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_s1_reg <= 3'h0;
            strap_s2_reg <= 3'h0;
            strap_s3_reg <= 3'h0;
            strap_reg    <= 3'h0;
        end
        else
        begin
            strap_s1_reg <= bus_addr_slot;
            strap_s2_reg <= strap_s1_reg;
            strap_s3_reg <= strap_s2_reg;
            if (strap_s2_reg == strap_s3_reg)
                strap_reg <= strap_s3_reg;
        end
    end

    // ************************************************************
    // decoded configuration
    // ************************************************************

    // playback slot source and word format decode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            decode_reg <= '{active_slot: 3'h0, word_len: AIC_LEN_24, format_reserved: 1'b0};
        else
        begin
            if (cfg_reg.slot_source_choice)
                decode_reg.active_slot <= slot_reg;
            else
                decode_reg.active_slot <= strap_reg;
            decode_reg.word_len        <= fmt_len(cfg_reg.serial_word_format);
            decode_reg.format_reserved <= fmt_len(cfg_reg.serial_word_format) == AIC_LEN_0;
        end
    end

    // ************************************************************
    // dc blocking high-pass filter
    // ************************************************************
    localparam int ACC_W = SAMPLE_W + DC_SHIFT + 1;

    logic signed [ACC_W-1:0]    acc_reg;
    logic signed [ACC_W-1:0]    x_ext;
    logic signed [ACC_W-1:0]    est_ext;
    logic signed [SAMPLE_W:0]   diff;
    logic [SAMPLE_W-1:0]        diff_sat;
    logic [SAMPLE_W-1:0]        sample_out_reg;
    logic                       sample_out_valid_reg;

    // acc holds the dc estimate scaled up by the shift
    assign x_ext   = ACC_W'($signed(sample_in));
    assign est_ext = acc_reg >>> DC_SHIFT;
    assign diff    = $signed({sample_in[SAMPLE_W-1], sample_in})
                   - $signed(est_ext[SAMPLE_W:0]);

    // clamp the difference back to the sample range
    always_comb
    begin
        if (diff[SAMPLE_W] != diff[SAMPLE_W-1])
            diff_sat = {diff[SAMPLE_W], {(SAMPLE_W-1){!diff[SAMPLE_W]}}};
        else
            diff_sat = diff[SAMPLE_W-1:0];
    end

    // estimator tracks the slow dc content of each sample
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            acc_reg <= '0;
        else if (sample_in_valid)
            acc_reg <= acc_reg + x_ext - est_ext;
    end

    // filtered or raw sample to the playback path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sample_out_reg       <= '0;
            sample_out_valid_reg <= 1'b0;
        end
        else
        begin
            sample_out_valid_reg <= sample_in_valid;
            if (sample_in_valid)
                sample_out_reg <= cfg_reg.dc_filter_skip ? sample_in : diff_sat;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign prdata           = prdata_reg;
    assign pready           = pready_reg;
    assign pslverr          = pslverr_reg;
    assign cfg              = cfg_reg;
    assign decode           = decode_reg;
    assign sample_out       = sample_out_reg;
    assign sample_out_valid = sample_out_valid_reg;
endmodule

// ==== bench/aic_config_asserts.sv ====
// Purpose: concurrent checks on the audio input configuration block
// Assumes: one clock pclk, async active-low presetn
// Notes:   config at byte 0x08, slot select at 0x0c
module aic_config_asserts
    import aic_pkg::*;
#(
    parameter int SAMPLE_W = 24   // sample width
)(
    input wire logic                  pclk,             // clock
    input wire logic                  presetn,          // reset
    input wire logic                  psel,             // select
    input wire logic                  penable,          // access
    input wire logic                  pwrite,           // direction
    input wire logic [AIC_ADDR_W-1:0] paddr,            // address
    input wire logic [AIC_DATA_W-1:0] pwdata,           // write data
    input wire logic [3:0]            pstrb,            // strobes
    input wire logic [AIC_DATA_W-1:0] prdata,           // read data
    input wire logic                  pready,           // ready
    input wire logic [2:0]            bus_addr_slot,    // strap pins
    input wire logic [SAMPLE_W-1:0]   sample_in,        // sample in
    input wire logic                  sample_in_valid,  // in strobe
    input wire logic [SAMPLE_W-1:0]   sample_out,       // sample out
    input wire logic                  sample_out_valid, // out strobe
    input wire aic_cfg_t              cfg,              // config
    input wire aic_decode_t           decode            // decode
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // checks
    // ************************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [2:0] slot_m;  // mirror of the slot select field

    // follow completed slot writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            slot_m <= 3'h0;
        else if (psel && penable && pready && pwrite && paddr == 10'h00c && pstrb[0])
            slot_m <= pwdata[2:0];
    end

    function automatic logic [4:0] wlen(input logic [2:0] f);
        return f == 3'h0 ? AIC_LEN_24 : f == 3'h1 ? AIC_LEN_20 : f == 3'h2 ? AIC_LEN_18 :
               f == 3'h3 ? AIC_LEN_16 : f < 3'h6 ? AIC_LEN_24 : AIC_LEN_0;
    endfunction

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence done_s;
        psel && penable && pready;
    endsequence

    cfg_write_a: assert property (done_s ##0 pwrite && paddr == 10'h008 && pstrb[0]
        |=> cfg == $past(pwdata[7:0])) else $error("config write lost");
    cfg_read_a: assert property (done_s ##0 !pwrite && paddr == 10'h008
        |-> prdata == {24'h0, $past(cfg)}) else $error("config read wrong");
    apb_ready_a: assert property (setup_s |=> pready ##1 !pready)
        else $error("ready not one cycle");
    byp_pass_a: assert property (sample_in_valid && cfg.dc_filter_skip
        |=> sample_out == $past(sample_in)) else $error("bypass altered sample");
    out_valid_a: assert property (sample_out_valid == $past(sample_in_valid))
        else $error("sample strobe timing");
    fmt_len_a: assert property (decode.word_len == wlen($past(cfg.serial_word_format)))
        else $error("word length decode");
    slot_addr_a: assert property ((!cfg.slot_source_choice && $stable(bus_addr_slot))[*8]
        |-> decode.active_slot == bus_addr_slot) else $error("strap slot not used");
    slot_reg_a: assert property ((cfg.slot_source_choice && $stable(slot_m))[*4]
        |-> decode.active_slot == slot_m) else $error("register slot not used");
endmodule

// ==== bench/aic_config_bench.sv ====
// Purpose: self-checking bench for the audio input configuration block
// Assumes: 100 MHz pclk, DC_SHIFT set to 2
// Notes:   drivers queue expected results, monitors compare them
module aic_config_bench
    import aic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [9:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic        pready, pslverr, sample_out_valid, sample_in_valid = 0;
    logic [2:0]  strap = 3'h5;
    logic [3:0]  pstrb = 4'h1;
    logic [23:0] sample_in = '0, sample_out, x;
    logic [7:0]  v;
    aic_cfg_t    cfg;
    aic_decode_t decode;
    logic [32:0] rq[$];
    logic [23:0] sq[$];
    int          fails = 0, num_checks = 0, acc;

    always #5 pclk = ~pclk;

    aic_config #(.DC_SHIFT(2)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_addr_slot(strap),
        .sample_in(sample_in), .sample_in_valid(sample_in_valid), .sample_out(sample_out),
        .sample_out_valid(sample_out_valid), .cfg(cfg), .decode(decode));

    task results();
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task cmp_rd(input logic [32:0] e, input logic [32:0] s);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("mismatch read expected %h seen %h", e, s);
        end
    endtask

    task cmp_smp(input logic [23:0] e, input logic [23:0] s);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("mismatch sample expected %h seen %h", e, s);
        end
    endtask

    // one apb transfer; queues {pslverr, prdata}, read data masked to zero on writes
    task xfer(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [32:0] e);
        int n;
        @(posedge pclk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        rq.push_back(e);
        @(posedge pclk);
        penable <= 1;
        n = 0;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge pclk);
            n++;
        end
        if (pready !== 1'b1)
        begin
            fails++;
            results();
        end
        psel <= 0;
        penable <= 0;
    endtask

    task smp(input logic [23:0] s, input logic [23:0] e);
        @(posedge pclk);
        sample_in <= s;
        sample_in_valid <= 1;
        sq.push_back(e);
        @(posedge pclk);
        sample_in_valid <= 0;
    endtask

    // monitors take the oldest note when a result appears
    always @(posedge pclk)
        if (psel && penable && pready === 1'b1)
            cmp_rd(rq.pop_front(), pwrite ? {pslverr, 32'h0} : {pslverr, prdata});
    always @(posedge pclk)
        if (sample_out_valid === 1'b1)
            cmp_smp(sq.pop_front(), sample_out);

    initial
    begin
        void'($urandom(13252));
        repeat (12) @(posedge pclk);
        presetn <= 1;
        xfer(0, 10'h008, 0, 33'h004);
        xfer(0, 10'h00c, 0, 33'h000);
        xfer(0, 10'h0fc, 0, 33'h02d);
        $display("test reset done");
        acc = 0;
        for (int i = 0; i < 12; i++)
        begin
            smp(24'd400, 24'(400 - (acc >>> 2)));
            acc += 400 - (acc >>> 2);
        end
        $display("test filter done");
        // software keeps to the six legal format codes
        for (int f = 0; f < 6; f++)
        begin
            xfer(1, 10'h008, f, 0);
            xfer(0, 10'h008, 0, 33'(f));
            xfer(0, 10'h0fc, 0, 33'h02d);
        end
        $display("test formats done");
        xfer(1, 10'h00c, 3, 0);
        xfer(1, 10'h008, 32'h44, 0);
        repeat (4) @(posedge pclk);
        xfer(0, 10'h0fc, 0, 33'h02b);
        xfer(1, 10'h008, 32'h04, 0);
        strap <= 3'h2;
        repeat (10) @(posedge pclk);
        xfer(0, 10'h0fc, 0, 33'h012);
        pstrb <= 4'h0;
        xfer(1, 10'h008, 32'h05, 0);
        pstrb <= 4'h1;
        xfer(0, 10'h008, 0, 33'h004);
        xfer(0, 10'h010, 0, 33'h100000000);
        xfer(1, 10'h0fc, 32'hff, 33'h100000000);
        xfer(0, 10'h0fc, 0, 33'h012);
        $display("test slots done");
        for (int i = 0; i < 4; i++)
        begin
            v = 8'($urandom);
            v[5:4] = 2'h0;
            v[1] = v[1] & ~v[2];
            xfer(1, 10'h008, {24'h0, v}, 0);
            xfer(0, 10'h008, 0, {25'h0, v});
        end
        xfer(1, 10'h008, 32'h84, 0);
        for (int i = 0; i < 6; i++)
        begin
            x = 24'($urandom);
            smp(x, x);
        end
        repeat (4) @(posedge pclk);
        $display("test bypass done");
        results();
    end
endmodule

bind aic_config aic_config_asserts #(.SAMPLE_W(SAMPLE_W)) u_chk (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .bus_addr_slot(bus_addr_slot), .sample_in(sample_in), .sample_in_valid(sample_in_valid),
    .sample_out(sample_out), .sample_out_valid(sample_out_valid), .cfg(cfg), .decode(decode));
